//--- src/drive_cfg_pkg.sv
// Constants shared by the drive mode and auto-setup controller and its testbench.
// Assumes a single 25 MHz core clock and byte addressing on the register bus.
package drive_cfg_pkg;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned MS_PERIOD_NS  = 1000000;
	localparam int unsigned CYCLES_PER_MS = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Operating mode values
	localparam logic [7:0] MODE_AUTOSETUP      = 8'hfe;
	localparam logic [7:0] MODE_VELOCITY       = 8'h02;
	localparam logic [7:0] MODE_PROFILE_TORQUE = 8'h04;
	localparam logic [7:0] MODE_HOMING         = 8'h06;
	localparam logic [7:0] MODE_CS_TORQUE      = 8'h0a;
	// Homing methods -4..-1 search for a mechanical block
	localparam logic [7:0] HOMING_BLOCK_MIN    = 8'hfc;

	// Controlword
	localparam logic [15:0] CW_OP_MASK    = 16'h000f;
	localparam logic [15:0] CW_OP_ENABLED = 16'h000f;
	localparam logic [15:0] CW_STOP       = 16'h0006;
	localparam int          CW_START_BIT  = 4;

	// Statusword bits
	localparam int SW_OP_EN_BIT      = 2;
	localparam int SW_INDEX_BIT      = 10;
	localparam int SW_SETUP_DONE_BIT = 12;

	// Motor drive submode bits
	localparam int SUB_LOOP_BIT   = 0;
	localparam int SUB_REDUCE_BIT = 3;
	localparam int SUB_SLOW_BIT   = 7;

	// Motor configuration bits
	localparam int MC_BLDC_BIT = 0;
	localparam int MC_ENC_BIT  = 1;
	localparam int MC_HALL_BIT = 2;

	// Configuration error bits
	localparam int ERR_TORQUE_BIT = 0;
	localparam int ERR_MOTOR_BIT  = 1;
	localparam int ERR_SLOW_BIT   = 2;
	localparam int ERR_HOMING_BIT = 3;

	// Current scaling, per mille of rated current
	localparam logic [15:0] MAXCUR_FULL = 16'h03e8;
	localparam logic [26:0] PERMILLE    = 27'h00003e8;

	// Register byte addresses
	localparam logic [7:0] REG_MODE     = 8'h00;
	localparam logic [7:0] REG_CTL      = 8'h04;
	localparam logic [7:0] REG_STATUS   = 8'h08;
	localparam logic [7:0] REG_SUBMODE  = 8'h0c;
	localparam logic [7:0] REG_MAXCUR   = 8'h10;
	localparam logic [7:0] REG_RATED    = 8'h14;
	localparam logic [7:0] REG_IDLE_MS  = 8'h18;
	localparam logic [7:0] REG_RED_VAL  = 8'h1c;
	localparam logic [7:0] REG_TGT_VEL  = 8'h20;
	localparam logic [7:0] REG_MOTOR    = 8'h24;
	localparam logic [7:0] REG_PROG     = 8'h28;
	localparam logic [7:0] REG_CUR_SET  = 8'h2c;
	localparam logic [7:0] REG_CFG_ERR  = 8'h30;
	localparam logic [7:0] REG_HOMING   = 8'h34;
	localparam logic [7:0] STORE_BASE   = 8'h40;
	localparam logic [7:0] STORE_MASK   = 8'hf0;

	// Reset values
	localparam logic [7:0]  MODE_RST    = 8'h00;
	localparam logic [15:0] CTL_RST     = 16'h0000;
	localparam logic [7:0]  SUB_RST     = 8'h00;
	localparam logic [15:0] MAXCUR_RST  = 16'h03e8;

	// Persist categories and last result store index
	localparam logic [7:0] CAT_DRIVE = 8'h05;
	localparam logic [7:0] CAT_TUNE  = 8'h06;
	localparam logic [1:0] STORE_LAST = 2'h3;

endpackage

//--- src/drive_mode_autosetup_ctrl.sv
// Mode, auto-setup and open-loop current logic of a stepper/BLDC drive.
// Assumes a measurement engine on the setup_* ports and an Avalon-MM master.
//
// Notes on behaviour
// - Auto setup needs operation enabled in the power state machine.
// - Setting controlword bit 4 in auto-setup mode starts the run.
// - Statusword bit 12 goes high once the setup sequence has ended.
// - Statusword bit 10 reports whether an encoder index was found.
// - Successful setup copies results and persists drive and tuning categories.
// - Controlword value 6 stops the motor.
// - Torque modes refused in open-loop or slow-speed control.
// - Homing on block refused in open-loop control.
// - Open loop for steppers only; BLDC runs closed loop.
// - Slow-speed mode needs an encoder as feedback.
// - Open loop drives the full set current at every speed, except at standstill with reduction engaged.
// - Maximum current is per mille of rated current, default 1000.
// - Maximum current above 1000 is clamped to 1000.
// - Submode bit 0 selects the loop; zero means open loop.
// - Submode bit 3 enables standstill current reduction.
// - Reduction engages only after standstill for the idle time in ms.
// - Reduced open-loop standstill current is the reduction value of rated.
module drive_mode_autosetup_ctrl #(
	parameter int unsigned CYCLES_PER_MS = drive_cfg_pkg::CYCLES_PER_MS
) (
	input  wire logic        core_clk,        // Core clock, 25 MHz
	input  wire logic        sys_rst,         // Synchronous reset, high
	input  wire logic [7:0]  avs_address,     // Byte address
	input  wire logic        avs_read,        // Read request
	input  wire logic        avs_write,       // Write request
	input  wire logic [31:0] avs_writedata,   // Write data
	output logic      [31:0] avs_readdata,    // Read data
	output logic             avs_waitrequest, // Stall
	input  wire logic        setup_done,      // Measurement sequence ended, pulse
	input  wire logic        setup_ok,        // Sequence succeeded, with setup_done
	input  wire logic        setup_index,     // Index seen, with setup_done
	input  wire logic [31:0] res_resist,      // Identified winding resistance
	input  wire logic [31:0] res_induct,      // Identified winding inductance
	input  wire logic [31:0] res_flux,        // Identified interlinking flux
	input  wire logic [31:0] res_align,       // Identified alignment
	input  wire logic        setpoint_still,  // Set value indicates standstill
	output logic             setup_run,       // Measurement engine runs
	output logic             drive_enable,    // Power stage enabled
	output logic             open_loop,       // Open-loop control active
	output logic             slow_speed,      // Slow-speed control active
	output logic [31:0]      vel_target,      // Velocity set point to profile
	output logic [15:0]      current_set,     // Winding current set point, mA
	output logic             current_reduced, // Standstill reduction active
	output logic             persist_req,     // Store category request, pulse
	output logic [7:0]       persist_cat      // Category with persist_req
);
	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {BUS_IDLE, BUS_MEM, BUS_ACK} bus_t;
	typedef enum logic [2:0] {SU_IDLE, SU_RUN, SU_COPY, SU_PERSIST_DRIVE, SU_PERSIST_TUNE} su_t;

	typedef struct packed {
		bus_t        bus;
		logic        waitreq;
		logic [31:0] rdata;
		logic [7:0]  mode;
		logic [15:0] ctl;
		logic [7:0]  sub;
		logic [15:0] maxcur;
		logic [15:0] rated;
		logic [15:0] idle_ms;
		logic [15:0] red_val;
		logic [31:0] tgt_vel;
		logic [7:0]  mcfg;
		logic        prog_run;
		logic [7:0]  homing;
		su_t         su;
		logic        run;
		logic [1:0]  copy_idx;
		logic        done_bit;
		logic        index_bit;
		logic        start_seen;
		logic [15:0] ms_cnt;
		logic        ms_tick;
		logic        drive_en;
		logic        open_loop;
		logic        slow;
		logic [15:0] cur_set;
		logic        reduced;
		logic        persist_req;
		logic [7:0]  persist_cat;
		logic [31:0] vel_out;
	} state_t;

	state_t      st_r;
	state_t      st_nxt;
	logic [31:0] mem_rdata;
	logic        mem_we;
	logic [31:0] mem_wdata;
	logic        idle_expired;
	logic        idle_arm;
	logic        op_en;
	logic        torque_mode;
	logic        homing_block;
	logic [3:0]  cfg_err;
	logic [10:0] max_clamp;
	logic [10:0] red_clamp;
	logic [26:0] full_prod;
	logic [26:0] red_prod;
	logic [15:0] full_cur;
	logic [15:0] red_cur;
	logic [15:0] status_word;
	logic [31:0] reg_rd;
	logic        mem_hit;
	logic        start_cond;

	////////////////////////////////////////////////////////////////////////////
	param_store u_store (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.we       (mem_we),
		.waddr    (st_r.copy_idx),
		.wdata    (mem_wdata),
		.raddr    (avs_address[3:2]),
		.rdata_r  (mem_rdata)
	);

	idle_timer u_idle (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.arm       (idle_arm),
		.ms_tick   (st_r.ms_tick),
		.limit_ms  (st_r.idle_ms),
		.expired_r (idle_expired)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode and configuration checks, all from registered settings
	always_comb begin
		op_en = (st_r.ctl & drive_cfg_pkg::CW_OP_MASK) == drive_cfg_pkg::CW_OP_ENABLED;
		torque_mode = (st_r.mode == drive_cfg_pkg::MODE_PROFILE_TORQUE) ||
			(st_r.mode == drive_cfg_pkg::MODE_CS_TORQUE);
		homing_block = (st_r.mode == drive_cfg_pkg::MODE_HOMING) &&
			(st_r.homing >= drive_cfg_pkg::HOMING_BLOCK_MIN);
		cfg_err = 4'h0;
		cfg_err[drive_cfg_pkg::ERR_TORQUE_BIT] = torque_mode && (st_r.open_loop || st_r.slow);
		cfg_err[drive_cfg_pkg::ERR_HOMING_BIT] = homing_block && st_r.open_loop;
		// Hall feedback exists on BLDC motors only
		cfg_err[drive_cfg_pkg::ERR_MOTOR_BIT] = st_r.mcfg[drive_cfg_pkg::MC_BLDC_BIT] ?
			st_r.open_loop : st_r.mcfg[drive_cfg_pkg::MC_HALL_BIT];
		cfg_err[drive_cfg_pkg::ERR_SLOW_BIT] = st_r.slow &&
			!st_r.mcfg[drive_cfg_pkg::MC_ENC_BIT];
	end

	// Current scaling; a constant divider keeps software free of rounding rules
	always_comb begin
		max_clamp = (st_r.maxcur > drive_cfg_pkg::MAXCUR_FULL) ?
			drive_cfg_pkg::MAXCUR_FULL[10:0] : st_r.maxcur[10:0];
		red_clamp = (st_r.red_val > drive_cfg_pkg::MAXCUR_FULL) ?
			drive_cfg_pkg::MAXCUR_FULL[10:0] : st_r.red_val[10:0];
		full_prod = 27'(st_r.rated * max_clamp);
		red_prod = 27'(st_r.rated * red_clamp);
		full_cur = 16'(full_prod / drive_cfg_pkg::PERMILLE);
		red_cur = 16'(red_prod / drive_cfg_pkg::PERMILLE);
		idle_arm = st_r.open_loop && st_r.sub[drive_cfg_pkg::SUB_REDUCE_BIT] &&
			setpoint_still;
	end

	always_comb begin
		status_word = 16'h0000;
		status_word[drive_cfg_pkg::SW_OP_EN_BIT] = op_en;
		status_word[drive_cfg_pkg::SW_INDEX_BIT] = st_r.index_bit;
		status_word[drive_cfg_pkg::SW_SETUP_DONE_BIT] = st_r.done_bit;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read mux; unmapped addresses read zero
	always_comb begin
		mem_hit = (avs_address & drive_cfg_pkg::STORE_MASK) == drive_cfg_pkg::STORE_BASE;
		reg_rd = 32'h0000_0000;
		if (avs_address == drive_cfg_pkg::REG_MODE) begin
			reg_rd = {24'h000000, st_r.mode};
		end else if (avs_address == drive_cfg_pkg::REG_CTL) begin
			reg_rd = {16'h0000, st_r.ctl};
		end else if (avs_address == drive_cfg_pkg::REG_STATUS) begin
			reg_rd = {16'h0000, status_word};
		end else if (avs_address == drive_cfg_pkg::REG_SUBMODE) begin
			reg_rd = {24'h000000, st_r.sub};
		end else if (avs_address == drive_cfg_pkg::REG_MAXCUR) begin
			reg_rd = {16'h0000, st_r.maxcur};
		end else if (avs_address == drive_cfg_pkg::REG_RATED) begin
			reg_rd = {16'h0000, st_r.rated};
		end else if (avs_address == drive_cfg_pkg::REG_IDLE_MS) begin
			reg_rd = {16'h0000, st_r.idle_ms};
		end else if (avs_address == drive_cfg_pkg::REG_RED_VAL) begin
			reg_rd = {16'h0000, st_r.red_val};
		end else if (avs_address == drive_cfg_pkg::REG_TGT_VEL) begin
			reg_rd = st_r.tgt_vel;
		end else if (avs_address == drive_cfg_pkg::REG_MOTOR) begin
			reg_rd = {24'h000000, st_r.mcfg};
		end else if (avs_address == drive_cfg_pkg::REG_PROG) begin
			reg_rd = {31'h00000000, st_r.prog_run};
		end else if (avs_address == drive_cfg_pkg::REG_CUR_SET) begin
			reg_rd = {16'h0000, st_r.cur_set};
		end else if (avs_address == drive_cfg_pkg::REG_CFG_ERR) begin
			reg_rd = {28'h0000000, cfg_err};
		end else if (avs_address == drive_cfg_pkg::REG_HOMING) begin
			reg_rd = {24'h000000, st_r.homing};
		end
	end

	always_comb begin
		mem_we = st_r.su == SU_COPY;
		case (st_r.copy_idx)
			2'h0: mem_wdata = res_resist;
			2'h1: mem_wdata = res_induct;
			2'h2: mem_wdata = res_flux;
			default: mem_wdata = res_align;
		endcase
		start_cond = (st_r.su == SU_IDLE) &&
			(st_r.mode == drive_cfg_pkg::MODE_AUTOSETUP) &&
			op_en &&
			st_r.ctl[drive_cfg_pkg::CW_START_BIT] && !st_r.start_seen &&
			!st_r.prog_run;
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.persist_req = 1'b0;
		st_nxt.start_seen = st_r.ctl[drive_cfg_pkg::CW_START_BIT];

		// Bus slave: registers answer two edges after the request, the store three
		case (st_r.bus)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					if (mem_hit) begin
						st_nxt.bus = BUS_MEM;
					end else begin
						st_nxt.bus = BUS_ACK;
						st_nxt.waitreq = 1'b0;
						st_nxt.rdata = avs_read ? reg_rd : 32'h0000_0000;
					end
				end
			end
			BUS_MEM: begin
				st_nxt.bus = BUS_ACK;
				st_nxt.waitreq = 1'b0;
				st_nxt.rdata = avs_read ? mem_rdata : 32'h0000_0000;
			end
			default: begin
				st_nxt.bus = BUS_IDLE;
				st_nxt.waitreq = 1'b1;
				if (avs_write) begin
					if (avs_address == drive_cfg_pkg::REG_MODE) begin
						st_nxt.mode = avs_writedata[7:0];
					end else if (avs_address == drive_cfg_pkg::REG_CTL) begin
						st_nxt.ctl = avs_writedata[15:0];
					end else if (avs_address == drive_cfg_pkg::REG_SUBMODE) begin
						st_nxt.sub = avs_writedata[7:0];
					end else if (avs_address == drive_cfg_pkg::REG_MAXCUR) begin
						st_nxt.maxcur = avs_writedata[15:0];
					end else if (avs_address == drive_cfg_pkg::REG_RATED) begin
						st_nxt.rated = avs_writedata[15:0];
					end else if (avs_address == drive_cfg_pkg::REG_IDLE_MS) begin
						st_nxt.idle_ms = avs_writedata[15:0];
					end else if (avs_address == drive_cfg_pkg::REG_RED_VAL) begin
						st_nxt.red_val = avs_writedata[15:0];
					end else if (avs_address == drive_cfg_pkg::REG_TGT_VEL) begin
						st_nxt.tgt_vel = avs_writedata;
					end else if (avs_address == drive_cfg_pkg::REG_MOTOR) begin
						st_nxt.mcfg = avs_writedata[7:0];
					end else if (avs_address == drive_cfg_pkg::REG_PROG) begin
						st_nxt.prog_run = avs_writedata[0];
					end else if (avs_address == drive_cfg_pkg::REG_HOMING) begin
						st_nxt.homing = avs_writedata[7:0];
					end
				end
			end
		endcase

		// Auto-setup sequence
		case (st_r.su)
			SU_IDLE: begin
				if (start_cond) begin
					st_nxt.su = SU_RUN;
					st_nxt.done_bit = 1'b0;
					st_nxt.index_bit = 1'b0;
				end
			end
			SU_RUN: begin
				// Leaving operation enabled aborts; results are not trusted then
				if (!op_en || st_r.mode != drive_cfg_pkg::MODE_AUTOSETUP) begin
					st_nxt.su = SU_IDLE;
				end else if (setup_done) begin
					st_nxt.done_bit = 1'b1;
					st_nxt.index_bit = setup_index;
					st_nxt.copy_idx = 2'h0;
					st_nxt.su = setup_ok ? SU_COPY : SU_IDLE;
				end
			end
			SU_COPY: begin
				st_nxt.copy_idx = st_r.copy_idx + 2'h1;
				if (st_r.copy_idx == drive_cfg_pkg::STORE_LAST) begin
					st_nxt.su = SU_PERSIST_DRIVE;
					st_nxt.persist_req = 1'b1;
					st_nxt.persist_cat = drive_cfg_pkg::CAT_DRIVE;
				end
			end
			SU_PERSIST_DRIVE: begin
				st_nxt.su = SU_PERSIST_TUNE;
				st_nxt.persist_req = 1'b1;
				st_nxt.persist_cat = drive_cfg_pkg::CAT_TUNE;
			end
			default: begin
				st_nxt.su = SU_IDLE;
			end
		endcase
		st_nxt.run = st_nxt.su == SU_RUN;

		// Millisecond prescaler for the idle timer
		st_nxt.ms_tick = 1'b0;
		if (st_r.ms_cnt == 16'(CYCLES_PER_MS - 1)) begin
			st_nxt.ms_cnt = 16'h0000;
			st_nxt.ms_tick = 1'b1;
		end else begin
			st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
		end

		// Drive outputs; writing 6 drops operation enabled and stops the motor
		st_nxt.open_loop = !st_r.sub[drive_cfg_pkg::SUB_LOOP_BIT];
		st_nxt.slow = st_r.sub[drive_cfg_pkg::SUB_SLOW_BIT] && st_r.sub[drive_cfg_pkg::SUB_LOOP_BIT];
		st_nxt.drive_en = op_en && (cfg_err == 4'h0);
		st_nxt.vel_out = (op_en && st_r.mode == drive_cfg_pkg::MODE_VELOCITY) ?
			st_r.tgt_vel : 32'h0000_0000;
		st_nxt.reduced = idle_arm && idle_expired;
		// Full set current regardless of speed unless reduced at standstill
		st_nxt.cur_set = st_nxt.reduced ? red_cur : full_cur;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.bus <= BUS_IDLE;
			st_r.su <= SU_IDLE;
			st_r.waitreq <= 1'b1;
			st_r.mode <= drive_cfg_pkg::MODE_RST;
			st_r.ctl <= drive_cfg_pkg::CTL_RST;
			st_r.sub <= drive_cfg_pkg::SUB_RST;
			st_r.maxcur <= drive_cfg_pkg::MAXCUR_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata = st_r.rdata;
	assign avs_waitrequest = st_r.waitreq;
	assign setup_run = st_r.run;
	assign drive_enable = st_r.drive_en;
	assign open_loop = st_r.open_loop;
	assign slow_speed = st_r.slow;
	assign vel_target = st_r.vel_out;
	assign current_set = st_r.cur_set;
	assign current_reduced = st_r.reduced;
	assign persist_req = st_r.persist_req;
	assign persist_cat = st_r.persist_cat;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence good_finish_s;
		st_r.su == SU_RUN && op_en && st_r.mode == drive_cfg_pkg::MODE_AUTOSETUP &&
			setup_done && setup_ok;
	endsequence
	sequence persist_pair_s;
		(persist_req && persist_cat == drive_cfg_pkg::CAT_DRIVE) ##1
			(persist_req && persist_cat == drive_cfg_pkg::CAT_TUNE) ##1 !persist_req;
	endsequence

	setup_start_a: assert property (start_cond |=> setup_run)
		else $error("setup did not start");
	setup_gate_a: assert property ($rose(setup_run) |-> $past(op_en) && !$past(st_r.prog_run))
		else $error("setup started without operation enabled");
	done_clear_a: assert property ($rose(setup_run) |-> !st_r.done_bit)
		else $error("done bit not cleared at start");
	done_set_a: assert property (setup_run && setup_done && op_en &&
		st_r.mode == drive_cfg_pkg::MODE_AUTOSETUP |=> st_r.done_bit && !setup_run)
		else $error("done bit not set at end of setup");
	index_report_a: assert property (setup_run && setup_done && op_en &&
		st_r.mode == drive_cfg_pkg::MODE_AUTOSETUP |=> st_r.index_bit == $past(setup_index))
		else $error("index bit wrong");
	persist_seq_a: assert property (good_finish_s |-> ##5 persist_pair_s)
		else $error("results not persisted");
	motor_stop_a: assert property (st_r.ctl == drive_cfg_pkg::CW_STOP |=> !drive_enable)
		else $error("stop did not drop drive enable");
	torque_refuse_a: assert property (drive_enable |-> !$past(cfg_err[0]))
		else $error("torque mode enabled without feedback");
	homing_block_a: assert property (drive_enable |->
		!$past(homing_block && st_r.open_loop))
		else $error("homing on block in open loop");
	motor_loop_a: assert property (drive_enable |-> !$past(st_r.open_loop &&
		st_r.mcfg[drive_cfg_pkg::MC_BLDC_BIT]))
		else $error("bldc motor in open loop");
	clamp_full_a: assert property (!current_reduced |-> current_set == $past(full_cur) &&
		current_set <= st_r.rated)
		else $error("current not clamped");
	reduce_cond_a: assert property ($rose(current_reduced) |-> $past(idle_expired) &&
		$past(idle_arm) && current_set == $past(red_cur))
		else $error("reduction without idle time");
endmodule

//--- src/idle_timer.sv
// Millisecond standstill timer: counts ticks while armed, clears when disarmed.
// Assumes ms_tick is a one-cycle pulse once per millisecond.
module idle_timer (
	input  wire logic        core_clk,  // Core clock
	input  wire logic        sys_rst,   // Synchronous reset, high
	input  wire logic        arm,       // Standstill condition present
	input  wire logic        ms_tick,   // Millisecond pulse
	input  wire logic [15:0] limit_ms,  // Idle time in ms
	output logic             expired_r  // Idle time elapsed while armed
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        expired;
	} timer_t;

	timer_t st_r;
	timer_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (!arm) begin
			st_nxt = '0;
		end else if (!st_r.expired) begin
			if (st_r.cnt >= limit_ms) begin
				st_nxt.expired = 1'b1;
			end else if (ms_tick) begin
				st_nxt.cnt = st_r.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expired_r = st_r.expired;
endmodule

//--- src/param_store.sv
// Four-word store for identified motor parameters, registered read port.
// Assumes one writer and one reader in the core clock domain.
module param_store (
	input  wire logic        core_clk, // Core clock
	input  wire logic        sys_rst,  // Synchronous reset, high
	input  wire logic        we,       // Write strobe
	input  wire logic [1:0]  waddr,    // Write word index
	input  wire logic [31:0] wdata,    // Write data
	input  wire logic [1:0]  raddr,    // Read word index
	output logic      [31:0] rdata_r   // Read data, one cycle after raddr
);
	typedef struct packed {
		logic [3:0][31:0] mem;
		logic [31:0]      rdata;
	} store_t;

	store_t st_r;
	store_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = st_r.mem[raddr];
		if (we) begin
			st_nxt.mem[waddr] = wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_r = st_r.rdata;
endmodule

//--- tb/setup_engine_model.sv
// Measurement engine stand-in: answers each run with one done pulse.
// Assumes setup_run is a level that the controller holds for the whole run.
module setup_engine_model (
	input  wire logic core_clk,    // Core clock
	input  wire logic setup_run,   // Run request
	output logic      setup_done,  // Sequence ended, pulse
	output logic      setup_ok,    // Success, with done
	output logic      setup_index  // Index seen, with done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_r = 4'h0;
	logic       idx_r = 1'b1;
	// Qualifiers follow done so that they never look valid outside the pulse
	assign setup_ok = setup_done;
	// Index found on odd runs only, so both answers reach the controller
	assign setup_index = setup_done && idx_r;
	always @(posedge core_clk) begin
		setup_done <= setup_run && (cnt_r == 4'h6);
		if (setup_done) idx_r <= !idx_r;
		cnt_r <= !setup_run ? 4'h0 : (cnt_r == 4'h7 ? cnt_r : cnt_r + 4'h1);
	end
endmodule

//--- tb/test_drive_mode_autosetup_ctrl.sv
// Bench for the drive mode and auto-setup controller, driven over Avalon-MM.
// Assumes the engine model on the setup ports and a 4-cycle millisecond.
module test_drive_mode_autosetup_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q, vel_target;
	logic [31:0] res_resist = 32'h11, res_induct = 32'h22, res_flux = 32'h33, res_align = 32'h44;
	logic        avs_waitrequest, setup_done, setup_ok, setup_index, setpoint_still = 1'b0;
	logic        setup_run, drive_enable, open_loop, slow_speed, current_reduced, persist_req;
	logic [15:0] current_set;
	logic [7:0]  persist_cat;
	logic [7:0]  cats[$];
	int          n_fail = 0, n_compared = 0, i;
	drive_mode_autosetup_ctrl #(.CYCLES_PER_MS(4)) dut_u (.core_clk, .sys_rst, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .setup_done,
		.setup_ok, .setup_index, .res_resist, .res_induct, .res_flux, .res_align,
		.setpoint_still, .setup_run, .drive_enable, .open_loop, .slow_speed, .vel_target,
		.current_set, .current_reduced, .persist_req, .persist_cat);
	setup_engine_model eng_u (.core_clk, .setup_run, .setup_done, .setup_ok, .setup_index);
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) if (persist_req === 1'b1) cats.push_back(persist_cat);
	////////////////////////////////////////////////////////////////
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, q, exp);
	endtask
	task automatic poll;
		for (i = 0; i < 50 && q[12] !== 1'b1; i++) bus(1'b0, drive_cfg_pkg::REG_STATUS, 32'h0);
	endtask
	task automatic results;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge core_clk);
		n_fail++;
		results();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(drive_cfg_pkg::REG_MAXCUR, 32'h3e8, "maxcur");
		rd(8'h3c, 32'h0, "unmapped");
		wr(drive_cfg_pkg::REG_RATED, 32'h7d0);
		wr(drive_cfg_pkg::REG_MAXCUR, 32'h5dc);
		wr(drive_cfg_pkg::REG_CUR_SET, 32'h5);
		rd(drive_cfg_pkg::REG_CUR_SET, 32'h7d0, "clamp");
		chk("cur_full", {16'h0, current_set}, 32'h7d0);
		wr(drive_cfg_pkg::REG_RED_VAL, 32'h1f4);
		wr(drive_cfg_pkg::REG_IDLE_MS, 32'h2);
		wr(drive_cfg_pkg::REG_SUBMODE, 32'h8);
		setpoint_still <= 1'b1;
		for (i = 0; i < 100 && current_reduced !== 1'b1; i++) @(posedge core_clk);
		chk("idle_wait", 32'(i >= 8), 32'h1);
		repeat (2) @(posedge core_clk);
		chk("cur_red", {16'h0, current_set}, 32'h3e8);
		setpoint_still <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("red_off", {31'h0, current_reduced}, 32'h0);
		wr(drive_cfg_pkg::REG_MODE, drive_cfg_pkg::MODE_PROFILE_TORQUE);
		wr(drive_cfg_pkg::REG_CTL, 32'hf);
		rd(drive_cfg_pkg::REG_CFG_ERR, 32'h1, "torque_ol");
		chk("en_torque", {31'h0, drive_enable}, 32'h0);
		wr(drive_cfg_pkg::REG_CTL, 32'h6);
		wr(drive_cfg_pkg::REG_MODE, drive_cfg_pkg::MODE_VELOCITY);
		wr(drive_cfg_pkg::REG_TGT_VEL, 32'hc8);
		wr(drive_cfg_pkg::REG_CTL, 32'hf);
		repeat (2) @(posedge core_clk);
		chk("vel", vel_target, 32'hc8);
		chk("en_vel", {31'h0, drive_enable}, 32'h1);
		wr(drive_cfg_pkg::REG_CTL, 32'h6);
		repeat (2) @(posedge core_clk);
		chk("stop", {31'h0, drive_enable}, 32'h0);
		wr(drive_cfg_pkg::REG_MODE, drive_cfg_pkg::MODE_AUTOSETUP);
		wr(drive_cfg_pkg::REG_CTL, 32'hf);
		wr(drive_cfg_pkg::REG_CTL, 32'h1f);
		repeat (2) @(posedge core_clk);
		chk("run", {31'h0, setup_run}, 32'h1);
		poll();
		chk("done", {31'h0, q[12]}, 32'h1);
		chk("index", {31'h0, q[10]}, 32'h1);
		rd(drive_cfg_pkg::STORE_BASE, 32'h11, "store");
		repeat (2) @(posedge core_clk);
		chk("persist", {16'h0, cats[0], cats[1]}, 32'h0506);
		// A running user program must hold off the start
		wr(drive_cfg_pkg::REG_PROG, 32'h1);
		wr(drive_cfg_pkg::REG_CTL, 32'hf);
		wr(drive_cfg_pkg::REG_CTL, 32'h1f);
		repeat (2) @(posedge core_clk);
		chk("prog_hold", {31'h0, setup_run}, 32'h0);
		rd(drive_cfg_pkg::REG_STATUS, 32'h1404, "status_kept");
		wr(drive_cfg_pkg::REG_PROG, 32'h0);
		wr(drive_cfg_pkg::REG_CTL, 32'hf);
		wr(drive_cfg_pkg::REG_CTL, 32'h1f);
		repeat (2) @(posedge core_clk);
		chk("run2", {31'h0, setup_run}, 32'h1);
		rd(drive_cfg_pkg::REG_STATUS, 32'h4, "done_clr");
		poll();
		chk("status2", q, 32'h1004);
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(drive_cfg_pkg::REG_STATUS, 32'h0, "restart");
		chk("ol", {31'h0, open_loop}, 32'h1);
		wr(drive_cfg_pkg::REG_SUBMODE, 32'h81);
		rd(drive_cfg_pkg::REG_CFG_ERR, 32'h4, "slow_enc");
		chk("slow", {30'h0, slow_speed, open_loop}, 32'h2);
		wr(drive_cfg_pkg::REG_MOTOR, 32'h2);
		rd(drive_cfg_pkg::REG_CFG_ERR, 32'h0, "slow_ok");
		wr(drive_cfg_pkg::REG_SUBMODE, 32'h0);
		wr(drive_cfg_pkg::REG_MOTOR, 32'h1);
		rd(drive_cfg_pkg::REG_CFG_ERR, 32'h2, "bldc_ol");
		wr(drive_cfg_pkg::REG_MODE, drive_cfg_pkg::MODE_HOMING);
		wr(drive_cfg_pkg::REG_HOMING, 32'hfc);
		rd(drive_cfg_pkg::REG_CFG_ERR, 32'ha, "home_block");
		results();
	end
endmodule
